/* File: shared/cocb_defines.vh */
`ifndef COCB_DEFINES_VH
`define COCB_DEFINES_VH
// Command code framing for single-byte access.
`define COCB_CMD_BYTE_OP 3'h4
// Register byte offsets.
`define COCB_OFS_STOP_EN 5'h03
`define COCB_OFS_USB_FREE 5'h04
`define COCB_OFS_66_DOT 5'h05
`define COCB_OFS_SPREAD 5'h06
`define COCB_OFS_ID 5'h07
// Power-up values.
`define COCB_RST_STOP_EN 8'hFF
`define COCB_RST_USB_FREE 8'h47
`define COCB_RST_66_DOT 8'hDF
`define COCB_RST_SPREAD 8'h03
// Reserved bit masks and fixed values.
`define COCB_RSV_MASK_66_DOT 8'h40
`define COCB_RSV_VAL_66_DOT 8'h40
`define COCB_RSV_MASK_SPREAD 8'hC0
`define COCB_RSV_VAL_SPREAD 8'h00
// Field positions.
`define COCB_BIT_SW_STOP 7
`define COCB_BIT_USB_DRIVE 7
`define COCB_BIT_USB_EN 6
`define COCB_BIT_DOT_EN 7
`define COCB_BIT_VCH_SEL 5
`define COCB_BIT_SEL_EN 4
`define COCB_BIT_TEST_MODE 5
`define COCB_BIT_SRC_FREQ 4
`define COCB_BIT_SS_MODE 3
`define COCB_BIT_SS_EN 2
// Identity codes, values arbitrary.
`define COCB_REVISION_CODE 4'h3
`define COCB_VENDOR_CODE 4'h5
// Restart latency in PCI clock periods.
`define COCB_RESUME_PERIODS 2
`endif

/* File: design/cocb_stop_sync.v */
`timescale 1ns/10ps
`include "cocb_defines.vh"
module cocb_stop_sync #(
   parameter WIDTH = 4
) (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Stop request and per-lane stoppable selects.
   input wire stop_req,
   input wire [WIDTH-1:0] stoppable,
   // Gated run enables, one per lane.
   output reg [WIDTH-1:0] run_reg
);
   reg stop_meta_reg;
   reg stop_sync_reg;
   // Two stages align the stop to the clock edge so no lane gets a short pulse.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stop_meta_reg <= 1'b0;
         stop_sync_reg <= 1'b0;
         run_reg <= {WIDTH{1'b1}};
      end else begin
         stop_meta_reg <= stop_req;
         stop_sync_reg <= stop_meta_reg;
         run_reg <= ~(stoppable & {WIDTH{stop_sync_reg}}); // RULE_15
      end
   end
endmodule

/* File: design/cocb_reg_bank.v */
`timescale 1ns/10ps
`include "cocb_defines.vh"
// Function
// RULE_01 - Writing 0 to the software stop bit stops all stoppable clocks on a clock edge.
// RULE_02 - Writing 1 restarts stopped clocks on a clock edge; the bit resets to 1.
// RULE_03 - Each output enable bit disables its output at 0 and enables it at 1.
// RULE_04 - Byte 4 bit 7 selects 48 MHz drive, 0 high and 1 low, reset 0.
// RULE_05 - Free-run select bits at 0 keep a free-running output running, at 1 let it stop.
// RULE_06 - Byte 5 bit 5 picks 66 MHz at 0 or 48 MHz at 1 for the shared output, reset 0.
// RULE_07 - Byte 6 bit 5 at 1 puts frequency select inputs in test mode, reset 0.
// RULE_08 - Byte 6 bit 4 selects 100 MHz at 0 or 200 MHz at 1 for the serial reference pair.
// RULE_09 - Byte 6 bit 3 selects down spread at 0 or center spread at 1.
// RULE_10 - Byte 6 bit 2 turns spread modulation off at 0 and on at 1, reset off.
// RULE_11 - Byte 7 is read only with a fixed revision nibble over a vendor nibble.
// RULE_12 - The host writes reserved bits with their fixed values only.
// RULE_13 - A byte access uses a command code 100 in the top bits and offset in the low five.
// RULE_14 - The effective stop is the AND of the active-low stop pin and the software bit.
// RULE_15 - Stopped clocks restart within two PCI periods after the stop is released; the free-running lanes take three.
module cocb_reg_bank (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Byte access port from the serial protocol engine.
   input wire [7:0] cmd_code,
   input wire wr_stb,
   input wire rd_stb,
   input wire [7:0] wr_data,
   // Read answer.
   output reg [7:0] rd_data_reg,
   output reg rd_valid_reg,
   output reg cmd_err_reg,
   // External active-low stop pin.
   input wire external_stop_pin_b,
   // Output enables.
   output reg [6:0] pci_en_reg,
   output reg [2:0] free_running_capable_outputs_en_reg,
   output reg usb_en_reg,
   output reg display_clock_output_en_reg,
   output reg [3:0] sixty_six_mhz_outputs_en_reg,
   output reg selectable_66_or_48_output_en_reg,
   output reg [1:0] ref_en_reg,
   // Stop gating for stoppable PCI and free-running capable outputs.
   output reg [6:0] pci_run_reg,
   output reg [2:0] free_run_reg,
   output reg stop_active_reg,
   // Mode controls.
   output reg usb_low_drive_reg,
   output reg forty_eight_mhz_mode_reg,
   output reg fs_test_mode_reg,
   output reg src_200mhz_reg,
   output reg ss_center_reg,
   output reg ss_enable_reg
);
   reg [7:0] stop_en_reg;
   reg [7:0] usb_free_reg;
   reg [7:0] sel_dot_reg;
   reg [7:0] spread_reg;
   wire [2:0] free_run_int;
   wire stop_req;
   wire [4:0] ofs;
   wire cmd_ok;

   // Command decode for byte operations.
   function is_byte_op;
      input [7:0] c;
      begin
         is_byte_op = (c[7:5] == `COCB_CMD_BYTE_OP);
      end
   endfunction

   assign ofs = cmd_code[4:0]; // RULE_13
   assign cmd_ok = is_byte_op(cmd_code); // RULE_13
   // Either low source stops the clocks, so the stop is active high here.
   assign stop_req = ~(external_stop_pin_b & stop_en_reg[`COCB_BIT_SW_STOP]); // RULE_14

   // Register writes; reserved bits are forced to fixed values so a bad host cannot disturb them.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stop_en_reg <= `COCB_RST_STOP_EN; // RULE_02
         usb_free_reg <= `COCB_RST_USB_FREE;
         sel_dot_reg <= `COCB_RST_66_DOT;
         spread_reg <= `COCB_RST_SPREAD;
      end else if (wr_stb && cmd_ok) begin
         case (ofs)
            `COCB_OFS_STOP_EN: stop_en_reg <= wr_data; // RULE_01
            `COCB_OFS_USB_FREE: usb_free_reg <= wr_data;
            `COCB_OFS_66_DOT: begin
               sel_dot_reg <= (wr_data & ~`COCB_RSV_MASK_66_DOT) | `COCB_RSV_VAL_66_DOT; // RULE_12
            end
            `COCB_OFS_SPREAD: begin
               spread_reg <= (wr_data & ~`COCB_RSV_MASK_SPREAD) | `COCB_RSV_VAL_SPREAD; // RULE_12
            end
            default: stop_en_reg <= stop_en_reg;
         endcase
      end
   end

   // Read path; byte 7 is fixed and writes to it are dropped.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
         cmd_err_reg <= 1'b0;
      end else begin
         rd_valid_reg <= rd_stb && cmd_ok;
         cmd_err_reg <= (rd_stb || wr_stb) && !cmd_ok;
         if (rd_stb && cmd_ok) begin
            case (ofs)
               `COCB_OFS_STOP_EN: rd_data_reg <= stop_en_reg;
               `COCB_OFS_USB_FREE: rd_data_reg <= usb_free_reg;
               `COCB_OFS_66_DOT: rd_data_reg <= sel_dot_reg;
               `COCB_OFS_SPREAD: rd_data_reg <= spread_reg;
               `COCB_OFS_ID: rd_data_reg <= {`COCB_REVISION_CODE, `COCB_VENDOR_CODE}; // RULE_11
               default: rd_data_reg <= 8'h00;
            endcase
         end
      end
   end

   // Stop alignment: PCI lanes are always stoppable, free-running lanes only when selected.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pci_run_reg <= 7'h7F;
         free_run_reg <= 3'h7;
         stop_active_reg <= 1'b0;
      end else begin
         pci_run_reg <= {7{~stop_req}} & pci_run_reg | {7{~stop_req}}; // RULE_01
         free_run_reg <= free_run_int; // RULE_05
         stop_active_reg <= stop_req; // RULE_02
      end
   end

   cocb_stop_sync #(
      .WIDTH(3)
   ) u_free_sync (
      .clk(clk),
      .rst_b(rst_b),
      .stop_req(stop_req),
      .stoppable(usb_free_reg[5:3]), // RULE_05
      .run_reg(free_run_int)
   );

   // Registered copies of the control fields drive the clock datapath.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pci_en_reg <= 7'h7F;
         free_running_capable_outputs_en_reg <= 3'h7;
         usb_en_reg <= 1'b1;
         display_clock_output_en_reg <= 1'b1;
         sixty_six_mhz_outputs_en_reg <= 4'hF;
         selectable_66_or_48_output_en_reg <= 1'b1;
         ref_en_reg <= 2'h3;
         usb_low_drive_reg <= 1'b0;
         forty_eight_mhz_mode_reg <= 1'b0;
         fs_test_mode_reg <= 1'b0;
         src_200mhz_reg <= 1'b0;
         ss_center_reg <= 1'b0;
         ss_enable_reg <= 1'b0;
      end else begin
         pci_en_reg <= stop_en_reg[6:0]; // RULE_03
         free_running_capable_outputs_en_reg <= usb_free_reg[2:0]; // RULE_03
         usb_en_reg <= usb_free_reg[`COCB_BIT_USB_EN]; // RULE_03
         display_clock_output_en_reg <= sel_dot_reg[`COCB_BIT_DOT_EN]; // RULE_03
         sixty_six_mhz_outputs_en_reg <= sel_dot_reg[3:0]; // RULE_03
         selectable_66_or_48_output_en_reg <= sel_dot_reg[`COCB_BIT_SEL_EN]; // RULE_03
         ref_en_reg <= spread_reg[1:0]; // RULE_03
         usb_low_drive_reg <= usb_free_reg[`COCB_BIT_USB_DRIVE]; // RULE_04
         forty_eight_mhz_mode_reg <= sel_dot_reg[`COCB_BIT_VCH_SEL]; // RULE_06
         fs_test_mode_reg <= spread_reg[`COCB_BIT_TEST_MODE]; // RULE_07
         src_200mhz_reg <= spread_reg[`COCB_BIT_SRC_FREQ]; // RULE_08
         ss_center_reg <= spread_reg[`COCB_BIT_SS_MODE]; // RULE_09
         ss_enable_reg <= spread_reg[`COCB_BIT_SS_EN]; // RULE_10
      end
   end
endmodule

/* File: dv/cocb_reg_bank_monitor.sv */
`timescale 1ns/10ps
`include "cocb_defines.vh"
module cocb_reg_bank_monitor (
   // Clock, reset and access port.
   input wire clk,
   input wire rst_b,
   input wire [7:0] cmd_code,
   input wire wr_stb,
   input wire rd_stb,
   input wire [7:0] wr_data,
   // Answers and controls.
   input wire [7:0] rd_data_reg,
   input wire rd_valid_reg,
   input wire cmd_err_reg,
   input wire external_stop_pin_b,
   input wire [6:0] pci_run_reg,
   input wire stop_active_reg,
   input wire usb_low_drive_reg,
   input wire ss_enable_reg
);
   // One clock domain, so every check shares one clock and is muted in reset.
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire good = cmd_code[7:5] == `COCB_CMD_BYTE_OP;
   bad_cmd_a: assert property ((wr_stb || rd_stb) && !good |=> cmd_err_reg)
      else $error("bad command not flagged");
   read_answer_a: assert property (rd_stb && good |=> rd_valid_reg && !cmd_err_reg)
      else $error("read not answered");
   id_value_a: assert property (rd_stb && cmd_code == 8'h87 |=>
      rd_data_reg == {`COCB_REVISION_CODE, `COCB_VENDOR_CODE}) else $error("id byte wrong");
   pin_flag_a: assert property (!external_stop_pin_b |=> stop_active_reg)
      else $error("pin stop not seen");
   stop_hold_a: assert property (stop_active_reg [*3] |-> pci_run_reg == 7'h00)
      else $error("clocks not stopped");
   resume_bound_a: assert property ($fell(stop_active_reg) |-> ##[0:3] pci_run_reg == 7'h7F)
      else $error("late resume");
   drive_sel_a: assert property (wr_stb && cmd_code == 8'h84 |->
      ##2 usb_low_drive_reg == $past(wr_data[7], 2)) else $error("drive bit wrong");
   spread_on_a: assert property (wr_stb && cmd_code == 8'h86 |->
      ##2 ss_enable_reg == $past(wr_data[2], 2)) else $error("spread bit wrong");
   cover property (rd_valid_reg);
   cover property (cmd_err_reg);
   cover property (stop_active_reg && pci_run_reg == 7'h00);
endmodule
bind cocb_reg_bank cocb_reg_bank_monitor u_cocb_reg_bank_monitor (.*);

/* File: dv/cocb_host.sv */
`timescale 1ns/10ps
module cocb_host (
   // Clock and answers.
   input wire clk,
   input wire [7:0] rd_data_reg,
   input wire rd_valid_reg,
   input wire cmd_err_reg,
   // Requests.
   output logic [7:0] cmd_code = 8'h00,
   output logic [7:0] wr_data = 8'h00,
   output logic wr_stb = 1'h0,
   output logic rd_stb = 1'h0
);
   // One byte access; released lines show the inverse so stale values never look held.
   task acc(input logic w, input logic [7:0] c, d, output logic [7:0] q, output logic e);
      integer i;
      begin
         @(negedge clk);
         cmd_code = c;
         wr_data = d;
         wr_stb = w;
         rd_stb = !w;
         @(negedge clk);
         wr_stb = 1'h0;
         rd_stb = 1'h0;
         cmd_code = ~c;
         wr_data = ~d;
         q = 8'hXX;
         e = 1'h0;
         for (i = 0; i < 3; i++) begin
            if (rd_valid_reg === 1'h1) q = rd_data_reg;
            if (cmd_err_reg === 1'h1) e = 1'h1;
            @(negedge clk);
         end
      end
   endtask
endmodule

/* File: dv/cocb_reg_bank_test.sv */
`timescale 1ns/10ps
`include "cocb_defines.vh"
module cocb_reg_bank_test;
   logic clk = 0;
   logic rst_b = 0;
   logic external_stop_pin_b = 1;
   logic [7:0] q;
   logic e;
   integer fails = 0;
   integer check_count = 0;
   wire [7:0] cmd_code, wr_data, rd_data_reg;
   wire wr_stb, rd_stb, rd_valid_reg, cmd_err_reg, usb_en_reg, display_clock_output_en_reg;
   wire selectable_66_or_48_output_en_reg, stop_active_reg, usb_low_drive_reg, src_200mhz_reg;
   wire forty_eight_mhz_mode_reg, fs_test_mode_reg, ss_center_reg, ss_enable_reg;
   wire [6:0] pci_en_reg, pci_run_reg;
   wire [2:0] free_running_capable_outputs_en_reg, free_run_reg;
   wire [3:0] sixty_six_mhz_outputs_en_reg;
   wire [1:0] ref_en_reg;
   wire [24:0] fields = {pci_en_reg, free_running_capable_outputs_en_reg, usb_en_reg,
      display_clock_output_en_reg, sixty_six_mhz_outputs_en_reg,
      selectable_66_or_48_output_en_reg, ref_en_reg, usb_low_drive_reg,
      forty_eight_mhz_mode_reg, fs_test_mode_reg, src_200mhz_reg, ss_center_reg, ss_enable_reg};
   wire [10:0] runs = {pci_run_reg, free_run_reg, stop_active_reg};
   cocb_reg_bank u_cocb_reg_bank (.*);
   cocb_host u_cocb_host (.clk(clk), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
      .cmd_err_reg(cmd_err_reg), .cmd_code(cmd_code), .wr_data(wr_data), .wr_stb(wr_stb),
      .rd_stb(rd_stb));
   initial forever #25 clk = ~clk;
   task chk(input logic [31:0] g, x);
      begin
         check_count++;
         if (g !== x) begin
            fails++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, x);
         end
      end
   endtask
   task idle(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task test_done;
      begin
         if (fails == 0 && check_count > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // Power-up field values, then every mode bit flipped with reserved bits kept.
   task t_modes;
      begin
         chk(fields, 25'h1FFFFC0);
         u_cocb_host.acc(1, 8'h86, 8'h3C, q, e);
         u_cocb_host.acc(1, 8'h84, 8'hB8, q, e);
         u_cocb_host.acc(1, 8'h85, 8'h60, q, e);
         chk(fields, 25'h1FC003F);
      end
   endtask
   // Software stop with lanes stoppable, then the pin with lanes free running.
   task t_stop;
      begin
         u_cocb_host.acc(1, 8'h83, 8'h7F, q, e);
         idle(2);
         chk(runs, 11'h001);
         u_cocb_host.acc(1, 8'h83, 8'hFF, q, e);
         idle(2);
         chk(runs, 11'h7FE);
         u_cocb_host.acc(1, 8'h84, 8'h87, q, e);
         external_stop_pin_b = 0;
         idle(4);
         chk(runs, 11'h00F);
         external_stop_pin_b = 1;
         idle(4);
         chk(runs, 11'h7FE);
      end
   endtask
   // Bad command, write to the read-only byte and an unmapped read.
   task t_refuse;
      begin
         u_cocb_host.acc(1, 8'h66, 8'h00, q, e);
         chk(e, 32'h1);
         chk(ss_enable_reg, 32'h1);
         u_cocb_host.acc(1, 8'h87, 8'h00, q, e);
         u_cocb_host.acc(0, 8'h87, 8'h00, q, e);
         chk(q, {`COCB_REVISION_CODE, `COCB_VENDOR_CODE});
         u_cocb_host.acc(0, 8'h88, 8'h00, q, e);
         chk(q, 32'h0);
      end
   endtask
   // Reset for two cycles, then the scenarios in turn.
   initial begin
      idle(2);
      rst_b = 1;
      t_modes;
      t_stop;
      t_refuse;
      test_done;
   end
endmodule
